// file: smd_pkg.sv
package smd_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int SMD_CLK_MHZ = 250;
   // Power-down recovery the controller must allow after re-enable
   localparam int SMD_RECOV_TIME_US = 1000;
   localparam int SMD_RECOV_CYCLES = SMD_RECOV_TIME_US * SMD_CLK_MHZ;
   // Quiet time on the step line before holding current is cut back
   localparam int SMD_IDLE_TIME_US = 50000;
   localparam int SMD_IDLE_CYCLES = SMD_IDLE_TIME_US * SMD_CLK_MHZ;
   localparam int SMD_TMR_W = 24;

   // ----------------------------------------------------------------
   // Resolution and phase
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SMD_RES_FULL,
      SMD_RES_HALF,
      SMD_RES_QUARTER,
      SMD_RES_EIGHTH
   } smd_res_t;

   localparam int SMD_PH_W = 5;
   localparam logic [4:0] SMD_INC_FULL = 5'h08;
   localparam logic [4:0] SMD_INC_HALF = 5'h04;
   localparam logic [4:0] SMD_INC_QUARTER = 5'h02;
   localparam logic [4:0] SMD_INC_EIGHTH = 5'h01;
   localparam logic [4:0] SMD_PH_QUARTER_TURN = 5'h08;
   localparam logic [3:0] SMD_TBL_LAST = 4'h8;
   localparam logic [7:0] SMD_SINE_TBL [0:8] = '{
      8'h00, 8'h32, 8'h62, 8'h8e, 8'hb4, 8'hd4, 8'hec, 8'hfb, 8'hff
   };

   // Holding current in percent of running current
   localparam logic [6:0] SMD_PCT_CUTBACK = 7'h17;
   localparam logic [6:0] SMD_PCT_FULL = 7'h64;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int SMD_ADDR_W = 8;
   localparam logic [7:0] SMD_REG_CTRL = 8'h00;
   localparam logic [7:0] SMD_REG_STATUS = 8'h04;
   localparam logic [7:0] SMD_REG_POS = 8'h08;
   localparam logic [7:0] SMD_REG_PHASE = 8'h0c;

   localparam int SMD_CTRL_SOFT_DIS = 0;
   localparam int SMD_ST_RES_LO = 0;
   localparam int SMD_ST_CW = 2;
   localparam int SMD_ST_EN = 3;
   localparam int SMD_ST_CUTBACK = 4;
   localparam int SMD_ST_EDGE_POS = 5;
   localparam int SMD_ST_RECOV = 6;
   localparam int SMD_ST_RES_ERR = 7;
   localparam int SMD_PHR_COS_LO = 8;
   localparam int SMD_PHR_SIN_LO = 17;

endpackage

// file: smd_step_edge.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Step edge detector with polarity caught at power-up
// ----------------------------------------------------------------
module smd_step_edge (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic step_i,
   input wire logic edge_sel_pos_i,
   output logic edge_pos_o,
   output logic step_edge_o
);
   logic step_q, step_d;
   logic pol_q, pol_d;

   always_comb begin
      step_d = step_i;
      // Polarity only follows the switch while reset is held
      pol_d = pol_q;
      step_edge_o = pol_q ? (step_i & ~step_q) : (~step_i & step_q); // RULE_06
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         // Sampled at power-up only; later moves are ignored
         pol_q <= edge_sel_pos_i; // RULE_07
         // Idle level of the pulled-up line, else rising mode sees a false edge
         step_q <= 1'b1;
      end else if (ce_i) begin
         pol_q <= pol_d;
         step_q <= step_d;
      end
   end

   assign edge_pos_o = pol_q;
endmodule // smd_step_edge

// file: smd_timer.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Restartable one-shot interval timer
// ----------------------------------------------------------------
module smd_timer #(
   parameter int LIMIT = 16
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic restart_i,
   output logic expired_o
);
   logic [smd_pkg::SMD_TMR_W-1:0] cnt_q, cnt_d;
   logic [smd_pkg::SMD_TMR_W-1:0] limit_c;

   always_comb begin
      limit_c = smd_pkg::SMD_TMR_W'(LIMIT - 1);
      cnt_d = cnt_q;
      if (restart_i) begin
         cnt_d = '0;
      end else if (cnt_q != limit_c) begin
         cnt_d = cnt_q + 1'b1;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cnt_q <= '0;
      end else if (ce_i) begin
         cnt_q <= cnt_d;
      end
   end

   assign expired_o = (cnt_q == limit_c);
endmodule // smd_timer

// file: smd_step_dir.sv
`timescale 1ns/100ps
// How it works
// RULE_01 - Two select lines pick full/half/quarter/eighth
// RULE_02 - High driven select level counts as closed
// RULE_03 - Enable line closed disables motor outputs
// RULE_04 - Direction closed clockwise, open counterclockwise
// RULE_05 - All open: eighth, CCW, enabled, cutback
// RULE_06 - One step per selected step edge
// RULE_07 - Edge polarity taken only at power-up
// RULE_08 - Controller keeps resolution still while stepping
// RULE_09 - Idle cutback to 23 percent, else 100
// RULE_10 - Controller waits 1 ms after re-enable
// RULE_11 - Each step moves phase by resolution increment
module smd_step_dir #(
   parameter int IDLE_CYCLES = smd_pkg::SMD_IDLE_CYCLES,
   parameter int RECOV_CYCLES = smd_pkg::SMD_RECOV_CYCLES
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic step_i,
   input wire logic dir_closed_i,
   input wire logic disable_closed_i,
   input wire logic resolution_select_a_i,
   input wire logic resolution_select_b_i,
   input wire logic edge_sel_pos_i,
   input wire logic cutback_en_i,
   input wire logic [smd_pkg::SMD_ADDR_W-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   output logic out_en_o,
   output logic dir_cw_o,
   output logic [1:0] resolution_o,
   output logic [smd_pkg::SMD_PH_W-1:0] phase_o,
   output logic cos_neg_o,
   output logic [7:0] cos_mag_o,
   output logic sin_neg_o,
   output logic [7:0] sin_mag_o,
   output logic [6:0] current_pct_o,
   output logic step_taken_o
);

   // ----------------------------------------------------------------
   // Sub-blocks
   // ----------------------------------------------------------------
   logic step_edge;
   logic edge_pos;
   logic idle_expired;
   logic recov_done;
   logic enabled_c;
   logic step_ok;
   logic enable_rise;

   smd_step_edge u_edge (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .step_i(step_i),
      .edge_sel_pos_i(edge_sel_pos_i),
      .edge_pos_o(edge_pos),
      .step_edge_o(step_edge)
   );

   // Idle timer restarts on every accepted step
   smd_timer #(
      .LIMIT(IDLE_CYCLES)
   ) u_idle (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .restart_i(step_ok),
      .expired_o(idle_expired)
   );

   // Recovery window is reported only, never enforced
   smd_timer #(
      .LIMIT(RECOV_CYCLES)
   ) u_recov (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .restart_i(enable_rise),
      .expired_o(recov_done)
   );

   // ----------------------------------------------------------------
   // Sine lookup, one quarter wave mirrored into four quadrants
   // ----------------------------------------------------------------
   // Bit 4 carries the sign, bit 3 mirrors the quarter wave
   function automatic logic [8:0] smd_sine(input logic [smd_pkg::SMD_PH_W-1:0] idx);
      logic [2:0] k;
      logic [3:0] sel;
      logic [8:0] res;
      k = idx[2:0];
      sel = idx[3] ? (smd_pkg::SMD_TBL_LAST - {1'b0, k}) : {1'b0, k};
      res = {idx[4], smd_pkg::SMD_SINE_TBL[sel]};
      return res;
   endfunction

   // ----------------------------------------------------------------
   // Input decode
   // ----------------------------------------------------------------
   smd_pkg::smd_res_t res_c;
   logic [smd_pkg::SMD_PH_W-1:0] inc_c;

   always_comb begin
      // Closed contact and driven high look the same here
      case ({resolution_select_a_i, resolution_select_b_i}) // RULE_02
         2'b11: res_c = smd_pkg::SMD_RES_FULL; // RULE_01
         2'b10: res_c = smd_pkg::SMD_RES_HALF;
         2'b01: res_c = smd_pkg::SMD_RES_QUARTER;
         2'b00: res_c = smd_pkg::SMD_RES_EIGHTH; // RULE_05
         default: res_c = smd_pkg::SMD_RES_EIGHTH;
      endcase
      // Increment in table steps, eight per full step
      case (res_c)
         smd_pkg::SMD_RES_FULL: inc_c = smd_pkg::SMD_INC_FULL; // RULE_11
         smd_pkg::SMD_RES_HALF: inc_c = smd_pkg::SMD_INC_HALF;
         smd_pkg::SMD_RES_QUARTER: inc_c = smd_pkg::SMD_INC_QUARTER;
         smd_pkg::SMD_RES_EIGHTH: inc_c = smd_pkg::SMD_INC_EIGHTH;
         default: inc_c = smd_pkg::SMD_INC_EIGHTH;
      endcase
   end

   // ----------------------------------------------------------------
   // Control and status state
   // ----------------------------------------------------------------
   logic soft_dis_q, soft_dis_d;
   logic en_prev_q, en_prev_d;
   logic res_err_q, res_err_d;
   logic [1:0] res_prev_q, res_prev_d;
   logic res_clr_c;

   // Soft disable ORs with the pin, either one stops the drive
   assign enabled_c = ~disable_closed_i & ~soft_dis_q; // RULE_03
   // Enable rise restarts the recovery window
   assign enable_rise = enabled_c & ~en_prev_q;
   // Steps taken while disabled are dropped, the index stays put
   assign step_ok = step_edge & enabled_c;

   always_comb begin
      soft_dis_d = soft_dis_q;
      res_clr_c = 1'b0;
      // Unmapped writes fall through and change nothing
      if (wr_i && addr_i == smd_pkg::SMD_REG_CTRL) begin
         soft_dis_d = wdata_i[smd_pkg::SMD_CTRL_SOFT_DIS];
      end
      if (wr_i && addr_i == smd_pkg::SMD_REG_STATUS) begin
         res_clr_c = wdata_i[smd_pkg::SMD_ST_RES_ERR];
      end
      en_prev_d = enabled_c;
      res_prev_d = res_c;
      // Flags a resolution change under an enabled drive; set beats clear
      res_err_d = res_err_q & ~res_clr_c;
      if (enabled_c && res_prev_q != res_c) begin
         res_err_d = 1'b1; // RULE_08
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         soft_dis_q <= 1'b0;
         en_prev_q <= 1'b0;
         res_err_q <= 1'b0;
         res_prev_q <= smd_pkg::SMD_RES_EIGHTH;
      end else if (ce_i) begin
         soft_dis_q <= soft_dis_d;
         en_prev_q <= en_prev_d;
         res_err_q <= res_err_d;
         res_prev_q <= res_prev_d;
      end
   end

   // ----------------------------------------------------------------
   // Phase index, position and drive outputs
   // ----------------------------------------------------------------
   logic [smd_pkg::SMD_PH_W-1:0] phase_q, phase_d;
   logic [31:0] pos_q, pos_d;
   logic out_en_q, out_en_d;
   logic dir_cw_q, dir_cw_d;
   logic [1:0] res_q, res_d;
   logic [8:0] cos_q, cos_d;
   logic [8:0] sin_q, sin_d;
   logic [6:0] pct_q, pct_d;
   logic taken_q, taken_d;
   logic cutback_q, cutback_d;

   always_comb begin
      // Index wraps modulo 32, the table mirrors it
      phase_d = phase_q;
      pos_d = pos_q;
      if (step_ok) begin
         if (dir_closed_i) begin
            phase_d = phase_q + inc_c; // RULE_04
            pos_d = pos_q + {27'h0, inc_c};
         end else begin
            phase_d = phase_q - inc_c; // RULE_11
            pos_d = pos_q - {27'h0, inc_c};
         end
      end
      // Preset wins over a step in the same cycle
      if (wr_i && addr_i == smd_pkg::SMD_REG_POS) begin
         pos_d = wdata_i;
      end
      // Levels follow their pins one cycle late
      out_en_d = enabled_c; // RULE_03
      dir_cw_d = dir_closed_i; // RULE_04
      res_d = res_c;
      // Amplitudes use the new index, so they line up with the step pulse
      sin_d = smd_sine(phase_d);
      // Coil A leads coil B by a quarter turn
      cos_d = smd_sine(phase_d + smd_pkg::SMD_PH_QUARTER_TURN);
      cutback_d = cutback_en_i & idle_expired & ~step_ok; // RULE_09
      pct_d = cutback_d ? smd_pkg::SMD_PCT_CUTBACK : smd_pkg::SMD_PCT_FULL; // RULE_09
      taken_d = step_ok; // RULE_06
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         // Reset state: eighth step and CCW, but outputs off and current at full
         phase_q <= '0;
         pos_q <= '0;
         out_en_q <= 1'b0;
         dir_cw_q <= 1'b0;
         res_q <= smd_pkg::SMD_RES_EIGHTH;
         sin_q <= '0;
         cos_q <= {1'b0, smd_pkg::SMD_SINE_TBL[smd_pkg::SMD_TBL_LAST]};
         pct_q <= smd_pkg::SMD_PCT_FULL;
         taken_q <= 1'b0;
         cutback_q <= 1'b0;
      end else if (ce_i) begin
         phase_q <= phase_d;
         pos_q <= pos_d;
         out_en_q <= out_en_d;
         dir_cw_q <= dir_cw_d;
         res_q <= res_d;
         sin_q <= sin_d;
         cos_q <= cos_d;
         pct_q <= pct_d;
         taken_q <= taken_d;
         cutback_q <= cutback_d;
      end
   end

   // ----------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------
   logic [31:0] rdata_q, rdata_d;
   logic [31:0] status_c;
   logic [31:0] phase_c;

   always_comb begin
      status_c = '0;
      status_c[smd_pkg::SMD_ST_RES_LO +: 2] = res_q;
      status_c[smd_pkg::SMD_ST_CW] = dir_cw_q;
      status_c[smd_pkg::SMD_ST_EN] = out_en_q;
      status_c[smd_pkg::SMD_ST_CUTBACK] = cutback_q;
      status_c[smd_pkg::SMD_ST_EDGE_POS] = edge_pos;
      status_c[smd_pkg::SMD_ST_RECOV] = ~recov_done;
      status_c[smd_pkg::SMD_ST_RES_ERR] = res_err_q;
      phase_c = '0;
      phase_c[smd_pkg::SMD_PH_W-1:0] = phase_q;
      phase_c[smd_pkg::SMD_PHR_COS_LO +: 9] = cos_q;
      phase_c[smd_pkg::SMD_PHR_SIN_LO +: 9] = sin_q;
      // Read data stand one cycle, then fall back to zero
      rdata_d = '0;
      if (rd_i) begin
         case (addr_i)
            smd_pkg::SMD_REG_CTRL: rdata_d = {31'h0, soft_dis_q};
            smd_pkg::SMD_REG_STATUS: rdata_d = status_c;
            smd_pkg::SMD_REG_POS: rdata_d = pos_q;
            smd_pkg::SMD_REG_PHASE: rdata_d = phase_c;
            default: rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rdata_q <= '0;
      end else if (ce_i) begin
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Every output is a flop, no logic after the registers
   assign rdata_o = rdata_q;
   assign out_en_o = out_en_q;
   assign dir_cw_o = dir_cw_q;
   assign resolution_o = res_q;
   assign phase_o = phase_q;
   assign cos_neg_o = cos_q[8];
   assign cos_mag_o = cos_q[7:0];
   assign sin_neg_o = sin_q[8];
   assign sin_mag_o = sin_q[7:0];
   assign current_pct_o = pct_q;
   assign step_taken_o = taken_q;

endmodule // smd_step_dir

// file: smd_step_dir_chk.sv
`timescale 1ns/100ps
// ------
// Pin-level checker
// ------
module smd_step_dir_chk #(
   parameter int IDLE_CYCLES = 20
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic step_i,
   input wire logic dir_closed_i,
   input wire logic disable_closed_i,
   input wire logic resolution_select_a_i,
   input wire logic resolution_select_b_i,
   input wire logic edge_sel_pos_i,
   input wire logic cutback_en_i,
   input wire logic out_en_o,
   input wire logic dir_cw_o,
   input wire logic [1:0] resolution_o,
   input wire logic [smd_pkg::SMD_PH_W-1:0] phase_o,
   input wire logic [6:0] current_pct_o,
   input wire logic step_taken_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);
   logic pol_q;
   logic [4:0] step_inc;
   int idle_q;
   assign step_inc = 5'h08 >> resolution_o;
   // Polarity only latched under reset, as at power-up
   always_ff @(posedge mclk_i) begin
      if (rst_i) pol_q <= edge_sel_pos_i;
   end
   // Saturates so long idle spans stay cheap
   always_ff @(posedge mclk_i) begin
      if (rst_i || step_taken_o) idle_q <= 0;
      else if (idle_q < IDLE_CYCLES + 8) idle_q <= idle_q + 1;
   end
   a_res_decode: assert property (1'b1 |=> resolution_o ==
      {~$past(resolution_select_a_i), ~$past(resolution_select_b_i)})
      else $error("resolution decode wrong");
   a_dir_follow: assert property (1'b1 |=> dir_cw_o == $past(dir_closed_i))
      else $error("direction wrong");
   a_dis_outputs: assert property (disable_closed_i |=> !out_en_o)
      else $error("outputs not disabled");
   a_dis_nostep: assert property (disable_closed_i |=> !step_taken_o)
      else $error("step taken while disabled");
   a_edge_pol: assert property (step_taken_o |->
      $past(step_i) == pol_q && $past(step_i, 2) != pol_q) else $error("step on wrong edge");
   a_step_once: assert property (step_taken_o |=> !step_taken_o)
      else $error("step pulse too long");
   a_phase_step: assert property (step_taken_o && $stable(dir_cw_o)
      && $stable(resolution_o) |->
      phase_o == (dir_cw_o ? $past(phase_o) + step_inc : $past(phase_o) - step_inc))
      else $error("phase increment wrong");
   a_phase_hold: assert property (!step_taken_o |-> $stable(phase_o))
      else $error("phase moved without step");
   a_cut_early: assert property (idle_q < IDLE_CYCLES - 3 |-> current_pct_o == 7'h64)
      else $error("cutback too early");
   a_cut_late: assert property (idle_q > IDLE_CYCLES + 3 && !step_taken_o
      && cutback_en_i && $past(cutback_en_i) |-> current_pct_o == 7'h17)
      else $error("cutback missing");
   a_cut_off: assert property (!cutback_en_i ##1 !cutback_en_i |-> current_pct_o == 7'h64)
      else $error("cutback while switched off");
   c_step_eighth: cover property (step_taken_o && resolution_o == 2'h3);
   c_cutback: cover property (current_pct_o == 7'h17);
   c_dis_drop: cover property (disable_closed_i ##1 !out_en_o);
endmodule // smd_step_dir_chk

// file: smd_ctl_model.sv
`timescale 1ns/100ps
// ------
// Step pulse source
// ------
module smd_ctl_model (
   input wire logic mclk_i,
   input wire logic go_i,
   input wire logic [3:0] n_i,
   output logic step_o,
   output logic busy_o
);
   logic [3:0] left_q = 4'h0;
   logic [1:0] ph_q = 2'h0;
   assign busy_o = left_q != 4'h0;
   // Line rests high through the pull-up; each level held two clocks
   assign step_o = !(busy_o && !ph_q[1]);
   // Pulses only on command, so the bench can keep pins still meanwhile
   always_ff @(posedge mclk_i) begin
      if (!busy_o) begin
         ph_q <= 2'h0;
         left_q <= go_i ? n_i : 4'h0;
      end else begin
         ph_q <= ph_q + 2'h1;
         if (ph_q == 2'h3) left_q <= left_q - 4'h1;
      end
   end
endmodule // smd_ctl_model

// file: smd_step_dir_tb_top.sv
`timescale 1ns/100ps
// ------
// Bench
// ------
module smd_step_dir_tb_top;
   localparam int IDLE = 20;
   localparam int RECOV = 10;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic dir_i = 1'b0;
   logic dis_i = 1'b0;
   logic sa_i = 1'b0;
   logic sb_i = 1'b0;
   logic esel_i = 1'b0;
   logic cut_i = 1'b1;
   logic go_i = 1'b0;
   logic [3:0] n_i = 4'h0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic step_i, busy, out_en_o, dir_cw_o, step_taken_o;
   logic [1:0] resolution_o;
   logic [4:0] phase_o, ph, inc;
   logic [6:0] current_pct_o;
   logic cos_neg_o, sin_neg_o;
   logic [7:0] cos_mag_o, sin_mag_o;
   logic [31:0] rdata_o, d;
   int n_fail = 0;
   int tests_run = 0;
   int n_step = 0;
   int cnt;
   always #2 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      if (step_taken_o === 1'b1) n_step <= n_step + 1;
   end
   smd_step_dir #(.IDLE_CYCLES(IDLE), .RECOV_CYCLES(RECOV)) dut (
      .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1), .step_i(step_i), .dir_closed_i(dir_i),
      .disable_closed_i(dis_i), .resolution_select_a_i(sa_i), .resolution_select_b_i(sb_i),
      .edge_sel_pos_i(esel_i), .cutback_en_i(cut_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .out_en_o(out_en_o), .dir_cw_o(dir_cw_o),
      .resolution_o(resolution_o), .phase_o(phase_o), .cos_neg_o(cos_neg_o),
      .cos_mag_o(cos_mag_o), .sin_neg_o(sin_neg_o), .sin_mag_o(sin_mag_o),
      .current_pct_o(current_pct_o), .step_taken_o(step_taken_o)
   );
   smd_ctl_model ctl (.mclk_i(mclk_i), .go_i(go_i), .n_i(n_i), .step_o(step_i), .busy_o(busy));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t mismatch got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   // Long settle also covers the recovery time after enable
   task automatic pins(input logic a, input logic b, input logic dr, input logic ds);
      @(posedge mclk_i);
      sa_i <= a;
      sb_i <= b;
      dir_i <= dr;
      dis_i <= ds;
      repeat (RECOV + 2) @(posedge mclk_i);
      #1;
   endtask
   task automatic steps(input logic [3:0] n);
      @(posedge mclk_i);
      go_i <= 1'b1;
      n_i <= n;
      @(posedge mclk_i);
      go_i <= 1'b0;
      #1;
      for (int k = 0; k < 99 && busy !== 1'b0; k++) begin
         @(posedge mclk_i);
         #1;
      end
      repeat (3) @(posedge mclk_i);
      #1;
   endtask
   task automatic test_done();
      if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #40000;
      n_fail++;
      test_done();
   end
   initial begin
      repeat (16) @(posedge mclk_i);
      rst_i <= 1'b0;
      repeat (RECOV + IDLE + 8) @(posedge mclk_i);
      #1;
      chk(resolution_o, 2'h3);
      chk({dir_cw_o, out_en_o}, 2'h1);
      chk(current_pct_o, 7'h17);
      for (int r = 0; r < 8; r++) begin
         // Resolution only moves while disabled, else the sticky resolution error is set
         pins(sa_i, sb_i, r[2], 1'b1);
         pins(~r[1], ~r[0], r[2], 1'b1);
         pins(~r[1], ~r[0], r[2], 1'b0);
         ph = phase_o;
         cnt = n_step;
         inc = 5'h08 >> r[1:0];
         steps(4'h3);
         ph = r[2] ? ph + 5'h03 * inc : ph - 5'h03 * inc;
         chk(n_step - cnt, 3);
         chk(phase_o, ph);
         chk(resolution_o, r[1:0]);
         chk(dir_cw_o, r[2]);
         chk(current_pct_o, 7'h64);
      end
      rd(smd_pkg::SMD_REG_STATUS);
      chk(d & 32'h000000ef, 32'h0f);
      rd(8'h40);
      chk(d, 32'h0);
      // The loop's moves cancel out, so the index is back at zero
      rd(smd_pkg::SMD_REG_PHASE);
      chk(d, 32'h0000ff00);
      chk({cos_neg_o, cos_mag_o, sin_neg_o, sin_mag_o}, {1'b0, 8'hff, 1'b0, 8'h00});
      pins(1'b0, 1'b0, 1'b1, 1'b1);
      ph = phase_o;
      steps(4'h2);
      chk({out_en_o, phase_o}, {1'b0, ph});
      wr(smd_pkg::SMD_REG_CTRL, 32'h1);
      pins(1'b0, 1'b0, 1'b1, 1'b0);
      chk(out_en_o, 1'b0);
      wr(smd_pkg::SMD_REG_CTRL, 32'h0);
      @(posedge mclk_i);
      cut_i <= 1'b0;
      repeat (IDLE + 8) @(posedge mclk_i);
      #1;
      chk(current_pct_o, 7'h64);
      @(posedge mclk_i);
      cut_i <= 1'b1;
      rst_i <= 1'b1;
      esel_i <= 1'b1;
      repeat (16) @(posedge mclk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      // Switch moved with power on must be ignored
      esel_i <= 1'b0;
      pins(1'b0, 1'b0, 1'b0, 1'b0);
      cnt = n_step;
      steps(4'h2);
      chk(n_step - cnt, 2);
      rd(smd_pkg::SMD_REG_STATUS);
      chk(d[5], 1'b1);
      // Two eighth steps counterclockwise from zero land on index 30
      chk(phase_o, 5'h1e);
      chk({cos_neg_o, cos_mag_o, sin_neg_o, sin_mag_o}, {1'b0, 8'hec, 1'b1, 8'h62});
      rd(smd_pkg::SMD_REG_POS);
      chk(d, 32'hfffffffe);
      wr(smd_pkg::SMD_REG_POS, 32'h40);
      rd(smd_pkg::SMD_REG_POS);
      chk(d, 32'h40);
      // Select moved under an enabled drive is flagged sticky
      pins(1'b1, 1'b0, 1'b0, 1'b0);
      rd(smd_pkg::SMD_REG_STATUS);
      chk(d & 32'h000000ef, 32'ha9);
      wr(smd_pkg::SMD_REG_STATUS, 32'h80);
      rd(smd_pkg::SMD_REG_STATUS);
      chk(d[7], 1'b0);
      test_done();
   end
endmodule // smd_step_dir_tb_top
bind smd_step_dir smd_step_dir_chk #(.IDLE_CYCLES(IDLE_CYCLES)) u_chk (
   .mclk_i(mclk_i), .rst_i(rst_i), .step_i(step_i), .dir_closed_i(dir_closed_i),
   .disable_closed_i(disable_closed_i), .resolution_select_a_i(resolution_select_a_i),
   .resolution_select_b_i(resolution_select_b_i), .edge_sel_pos_i(edge_sel_pos_i),
   .cutback_en_i(cutback_en_i), .out_en_o(out_en_o), .dir_cw_o(dir_cw_o),
   .resolution_o(resolution_o), .phase_o(phase_o), .current_pct_o(current_pct_o),
   .step_taken_o(step_taken_o)
);
